// *** common/fsh_params.svh ***
// Constants of the toggle-polling flash host: timing, register map, status bits.
// Assumes a 25 MHz clk_i; times are in ns and converted to cycles here.
`ifndef FSH_PARAMS_SVH
`define FSH_PARAMS_SVH

`define FSH_CLK_MHZ       25
`define FSH_SYNC_CYC      2
`define FSH_T_RD_NS       100
`define FSH_T_WP_NS       50
// Read strobe covers the access time plus the two-stage pin synchroniser
`define FSH_RD_CYC        ((((`FSH_T_RD_NS * `FSH_CLK_MHZ) + 999) / 1000) + `FSH_SYNC_CYC)
`define FSH_WP_CYC        (((`FSH_T_WP_NS * `FSH_CLK_MHZ) + 999) / 1000)

`define FSH_REG_CTRL      8'h00
`define FSH_REG_CFG       8'h04
`define FSH_REG_ADDR      8'h08
`define FSH_REG_STATUS    8'h0C

`define FSH_CTRL_START    0
`define FSH_CTRL_SINGLE   1
`define FSH_CTRL_RESET    2
`define FSH_CTRL_ABRST    3
`define FSH_CTRL_STOP     4
`define FSH_CFG_PACE_CE   0

`define FSH_ST_BUSY       0
`define FSH_ST_DONE       1
`define FSH_ST_PASS       2
`define FSH_ST_TOFAIL     3
`define FSH_ST_ABFAIL     4
`define FSH_ST_TB2TOG     5
`define FSH_ST_RDY        6
`define FSH_ST_BYTE_LSB   8

`define FSH_DQ_ABORT      1
`define FSH_DQ_TB2        2
`define FSH_DQ_ETIMER     3
`define FSH_DQ_TIMEOUT    5
`define FSH_DQ_TB1        6

`define FSH_CMD_ADDR1     12'h555
`define FSH_CMD_ADDR2     12'h2AA
`define FSH_CMD_UNLOCK1   8'hAA
`define FSH_CMD_UNLOCK2   8'h55
`define FSH_CMD_RESET     8'hF0

`endif

// *** common/fsh_pkg.sv ***
// Types of the toggle-polling flash host.
// Assumes fsh_params.svh supplies all numeric constants.
package fsh_pkg;

  typedef enum logic [2:0] {
    FSH_IDLE,
    FSH_RD_ACT,
    FSH_RD_GAP,
    FSH_EVAL,
    FSH_WR_ACT,
    FSH_WR_GAP
  } fsh_state_t;

endpackage : fsh_pkg

// *** rtl/fsh_poll_ctrl.sv ***
// Host controller that polls a parallel NOR flash's write-status byte over its pins.
// Assumes an APB master on clk_i and an asynchronous flash whose pins are resynchronised here.
//
// How it works
// R01 - Flash flips toggle bit one on every read while an operation runs.
// R02 - Toggle bit one is valid from the last command write and erase time-out.
// R03 - All-protected erase toggles about 100 us, then flash returns to array read.
// R04 - Program into protected sector toggles about 1 us, then array read.
// R05 - Erase suspend stops toggle bit one; active erase keeps it toggling.
// R06 - Programming inside erase suspend toggles bit one until that program ends.
// R07 - Toggle bit two flips on reads within sectors selected for erase.
// R08 - Host may pace status reads with output enable or chip select.
// R09 - Host reads status twice in a row; unchanged toggle bit means done.
// R10 - Still toggling with timeout flag set: recheck; still toggling means fail, reset.
// R11 - After pausing, host restarts polling from the first double read.
// R12 - Flash sets timeout flag when an operation exceeds its pulse limit.
// R13 - Programming a one over a zero halts and raises the timeout flag.
// R14 - After timeout failure host writes reset; flash returns to read mode.
// R15 - Erase timer flag stays zero during time-out, restarts per sector command.
// R16 - Host may skip the erase timer flag if sector commands come quickly.
// R17 - Erase timer flag one: flash ignores all commands but erase suspend.
// R18 - Host checks erase timer flag before and after each added sector command.
// R19 - Buffer abort flag set: host sends the buffer-abort reset sequence.
// R20 - During erase status shows poll 0, toggling bits, timer flag one, busy.
// R21 - During buffer writes host polls the last loaded buffer address.
// R22 - Host reads status at a valid address within the target sector.
// R23 - Complement poll bit shows inverted datum while programming, true after.
// R24 - Ready/busy line is low while erasing or programming, high otherwise.
// R25 - Erase-suspended sector read: poll bit one, toggle bit two toggling, ready.
`timescale 1ns/10ps
`include "fsh_params.svh"

module fsh_poll_ctrl
  import fsh_pkg::*;
#(
  parameter int AW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic      [AW-1:0] flash_addr_o,
  output logic               flash_ce_n_o,
  output logic               flash_oe_n_o,
  output logic               flash_we_n_o,
  input  wire logic [7:0]    flash_dq_i,
  output logic      [7:0]    flash_dq_o,
  output logic               flash_dq_oe_o,
  input  wire logic          ready_busy_line_i
);

  localparam logic [3:0] RD_CYC = 4'(`FSH_RD_CYC);
  localparam logic [3:0] WP_CYC = 4'(`FSH_WP_CYC);

  typedef struct packed {
    fsh_state_t    st;
    logic [3:0]    cnt;
    logic [1:0]    nread;
    logic [1:0]    step;
    logic          single;
    logic          stop;
    logic          pace_ce;
    logic [AW-1:0] poll_addr;
    logic [7:0]    last;
    logic          prev_tb1;
    logic          prev_tb2;
    logic          done;
    logic          pass;
    logic          to_fail;
    logic          ab_fail;
    logic          tb2_tog;
    logic [7:0]    dq_s1;
    logic [7:0]    dq_s2;
    logic          rb_s1;
    logic          rb_s2;
    logic          ce_n;
    logic          oe_n;
    logic          we_n;
    logic          dq_oe;
    logic [AW-1:0] a_o;
    logic [7:0]    d_o;
    logic [31:0]   rdata;
  } fsh_ctx_t;

  localparam fsh_ctx_t RST_VAL = '{
    st: FSH_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rb_s1: 1'b1, rb_s2: 1'b1,
    default: '0
  };

  fsh_ctx_t s_reg;
  fsh_ctx_t s_next;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `FSH_REG_CTRL) || (a == `FSH_REG_CFG) ||
                (a == `FSH_REG_ADDR) || (a == `FSH_REG_STATUS);
  endfunction : is_mapped

  // Command step 0..2: the abort reset uses all three, plain reset only the last
  function automatic logic [19:0] cmd_word(input logic [1:0] step);
    unique case (step)
      2'h0:    cmd_word = {`FSH_CMD_ADDR1, `FSH_CMD_UNLOCK1};
      2'h1:    cmd_word = {`FSH_CMD_ADDR2, `FSH_CMD_UNLOCK2};
      default: cmd_word = {`FSH_CMD_ADDR1, `FSH_CMD_RESET};
    endcase
  endfunction : cmd_word

  logic        wr_acc;
  logic        ctrl_wr;
  logic        tb1_tog;
  logic        tb2_now_tog;
  logic [31:0] rd_val;
  logic [19:0] cw;

  assign wr_acc      = psel_i & penable_i & pwrite_i;
  assign ctrl_wr     = wr_acc && (paddr_i == `FSH_REG_CTRL);
  assign tb1_tog     = s_reg.last[`FSH_DQ_TB1] != s_reg.prev_tb1;
  assign tb2_now_tog = s_reg.last[`FSH_DQ_TB2] != s_reg.prev_tb2;
  assign pready_o    = 1'b1;
  assign pslverr_o   = psel_i & penable_i & ~is_mapped(paddr_i);
  assign prdata_o      = s_reg.rdata;
  assign flash_addr_o  = s_reg.a_o;
  assign flash_ce_n_o  = s_reg.ce_n;
  assign flash_oe_n_o  = s_reg.oe_n;
  assign flash_we_n_o  = s_reg.we_n;
  assign flash_dq_o    = s_reg.d_o;
  assign flash_dq_oe_o = s_reg.dq_oe;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (paddr_i)
      `FSH_REG_CFG:    rd_val[`FSH_CFG_PACE_CE] = s_reg.pace_ce;
      `FSH_REG_ADDR:   rd_val[AW-1:0] = s_reg.poll_addr;
      `FSH_REG_STATUS: begin
        rd_val[`FSH_ST_BUSY]   = s_reg.st != FSH_IDLE;
        rd_val[`FSH_ST_DONE]   = s_reg.done;
        rd_val[`FSH_ST_PASS]   = s_reg.pass;
        rd_val[`FSH_ST_TOFAIL] = s_reg.to_fail;
        rd_val[`FSH_ST_ABFAIL] = s_reg.ab_fail;
        rd_val[`FSH_ST_TB2TOG] = s_reg.tb2_tog;
        rd_val[`FSH_ST_RDY]    = s_reg.rb_s2;
        rd_val[`FSH_ST_BYTE_LSB +: 8] = s_reg.last;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next       = s_reg;
    s_next.dq_s1 = flash_dq_i;
    s_next.dq_s2 = s_reg.dq_s1;
    s_next.rb_s1 = ready_busy_line_i;
    s_next.rb_s2 = s_reg.rb_s1;
    // Read data is captured in the setup phase so the access phase needs no wait
    if (psel_i && !penable_i) begin
      s_next.rdata = rd_val;
    end
    if (wr_acc && (paddr_i == `FSH_REG_CFG)) begin
      s_next.pace_ce = pwdata_i[`FSH_CFG_PACE_CE];
    end
    if (wr_acc && (paddr_i == `FSH_REG_ADDR)) begin
      s_next.poll_addr = pwdata_i[AW-1:0]; // R21
    end
    if (ctrl_wr && pwdata_i[`FSH_CTRL_STOP]) begin
      s_next.stop = 1'b1;
    end
    unique case (s_reg.st)
      FSH_IDLE: begin
        // Commands other than stop are dropped while busy; software checks busy first
        if (ctrl_wr && (pwdata_i[`FSH_CTRL_START] || pwdata_i[`FSH_CTRL_SINGLE])) begin
          s_next.single  = pwdata_i[`FSH_CTRL_SINGLE] & ~pwdata_i[`FSH_CTRL_START]; // R16 R18
          s_next.nread   = 2'h0; // R11
          s_next.stop    = 1'b0;
          s_next.done    = 1'b0;
          s_next.pass    = 1'b0;
          s_next.to_fail = 1'b0;
          s_next.ab_fail = 1'b0;
          s_next.tb2_tog = 1'b0;
          s_next.cnt     = RD_CYC;
          s_next.st      = FSH_RD_ACT;
        end else if (ctrl_wr && pwdata_i[`FSH_CTRL_ABRST]) begin
          s_next.done = 1'b0;
          s_next.step = 2'h0;
          s_next.cnt  = WP_CYC;
          s_next.st   = FSH_WR_ACT;
        end else if (ctrl_wr && pwdata_i[`FSH_CTRL_RESET]) begin
          s_next.done = 1'b0;
          s_next.step = 2'h2;
          s_next.cnt  = WP_CYC;
          s_next.st   = FSH_WR_ACT;
        end
      end
      FSH_RD_ACT: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          s_next.last = s_reg.dq_s2;
          s_next.st   = FSH_RD_GAP;
        end
      end
      FSH_RD_GAP: begin
        s_next.st = FSH_EVAL;
      end
      FSH_EVAL: begin
        s_next.prev_tb1 = s_reg.last[`FSH_DQ_TB1];
        s_next.prev_tb2 = s_reg.last[`FSH_DQ_TB2];
        s_next.cnt      = RD_CYC;
        if (s_reg.single) begin
          s_next.done = 1'b1;
          s_next.st   = FSH_IDLE;
        end else if (s_reg.nread == 2'h0) begin
          s_next.nread = 2'h1; // R09
          s_next.st    = FSH_RD_ACT;
        end else begin
          s_next.tb2_tog = s_reg.tb2_tog | tb2_now_tog;
          if (!tb1_tog) begin
            s_next.done = 1'b1; // R09
            s_next.pass = 1'b1;
            s_next.st   = FSH_IDLE;
          end else if (s_reg.last[`FSH_DQ_ABORT]) begin
            s_next.ab_fail = 1'b1; // R19
            s_next.step    = 2'h0;
            s_next.cnt     = WP_CYC;
            s_next.st      = FSH_WR_ACT;
          end else if (s_reg.nread == 2'h2) begin
            s_next.to_fail = 1'b1; // R10
            s_next.step    = 2'h2; // R14
            s_next.cnt     = WP_CYC;
            s_next.st      = FSH_WR_ACT;
          end else if (s_reg.last[`FSH_DQ_TIMEOUT]) begin
            s_next.nread = 2'h2; // R10
            s_next.st    = FSH_RD_ACT;
          end else if (s_reg.stop) begin
            // Leaving mid-poll; the next start reads twice again
            s_next.done = 1'b1; // R11
            s_next.st   = FSH_IDLE;
          end else begin
            s_next.st = FSH_RD_ACT;
          end
        end
      end
      FSH_WR_ACT: begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1) begin
          s_next.st = FSH_WR_GAP;
        end
      end
      FSH_WR_GAP: begin
        if (s_reg.step == 2'h2) begin
          s_next.done = 1'b1;
          s_next.st   = FSH_IDLE;
        end else begin
          s_next.step = s_reg.step + 2'h1;
          s_next.cnt  = WP_CYC;
          s_next.st   = FSH_WR_ACT;
        end
      end
    endcase
    // Pins follow the next state so they leave flip-flops without glitches
    s_next.ce_n  = !((s_next.st == FSH_RD_ACT) || (s_next.st == FSH_WR_ACT) ||
                     ((s_next.st == FSH_RD_GAP) && !s_reg.pace_ce)); // R08
    s_next.oe_n  = !((s_next.st == FSH_RD_ACT) ||
                     ((s_next.st == FSH_RD_GAP) && s_reg.pace_ce)); // R08
    s_next.we_n  = s_next.st != FSH_WR_ACT;
    s_next.dq_oe = (s_next.st == FSH_WR_ACT) || (s_next.st == FSH_WR_GAP);
    // Function results cannot be part-selected, so the command word lands in cw first
    cw = cmd_word(s_next.step);
    if (s_next.dq_oe) begin
      s_next.a_o = {{(AW-12){1'b0}}, cw[19:8]};
      s_next.d_o = cw[7:0];
    end else begin
      s_next.a_o = s_next.poll_addr; // R22
      s_next.d_o = cw[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= RST_VAL;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  double_read_a: assert property ( // R09
    (s_reg.st == FSH_EVAL) && (s_reg.nread == 2'h0) && !s_reg.single
    |=> (s_reg.st == FSH_RD_ACT) && (s_reg.nread == 2'h1) ##1 !flash_oe_n_o
  ) else $error("first read not followed by a second read");

  pass_no_toggle_a: assert property ( // R09
    (s_reg.st == FSH_EVAL) && (s_reg.nread != 2'h0) && !s_reg.single && !tb1_tog
    |=> s_reg.done && s_reg.pass && (s_reg.st == FSH_IDLE)
  ) else $error("steady toggle bit not reported as pass");

  timeout_recheck_a: assert property ( // R10
    (s_reg.st == FSH_EVAL) && (s_reg.nread == 2'h1) && !s_reg.single && tb1_tog &&
    !s_reg.last[`FSH_DQ_ABORT] && s_reg.last[`FSH_DQ_TIMEOUT]
    |=> (s_reg.nread == 2'h2) && !s_reg.done
  ) else $error("timeout flag did not trigger a recheck");

  fail_reset_a: assert property ( // R14
    (s_reg.st == FSH_EVAL) && (s_reg.nread == 2'h2) && tb1_tog &&
    !s_reg.last[`FSH_DQ_ABORT] && !s_reg.single
    |=> s_reg.to_fail && !flash_we_n_o && (flash_dq_o == `FSH_CMD_RESET)
        ##[1:20] s_reg.done
  ) else $error("timeout failure did not issue the reset command");

  abort_seq_a: assert property ( // R19
    (s_reg.st == FSH_EVAL) && (s_reg.nread != 2'h0) && tb1_tog && !s_reg.single &&
    s_reg.last[`FSH_DQ_ABORT]
    |=> (flash_dq_o == `FSH_CMD_UNLOCK1) && flash_dq_oe_o
        ##[1:10] (flash_dq_o == `FSH_CMD_UNLOCK2) ##[1:10] (flash_dq_o == `FSH_CMD_RESET)
  ) else $error("buffer abort did not send the abort reset sequence");

  restart_first_a: assert property ( // R11
    (s_reg.st == FSH_IDLE) && ctrl_wr && pwdata_i[`FSH_CTRL_START]
    |=> (s_reg.st == FSH_RD_ACT) && (s_reg.nread == 2'h0) && !s_reg.done
  ) else $error("poll start did not begin with a first read");

  pacing_pins_a: assert property ( // R08
    (s_reg.st == FSH_RD_GAP)
    |-> (s_reg.pace_ce ? (flash_ce_n_o && !flash_oe_n_o)
                       : (!flash_ce_n_o && flash_oe_n_o))
  ) else $error("read pacing strobe wrong between reads");

  poll_addr_a: assert property ( // R22
    (s_reg.st == FSH_RD_ACT) |-> (flash_addr_o == s_reg.poll_addr) && !flash_dq_oe_o
  ) else $error("status read not at the poll address");

  read_len_a: assert property ( // R08
    $fell(flash_oe_n_o) && (s_reg.st == FSH_RD_ACT) |-> !flash_oe_n_o [*5]
  ) else $error("read strobe shorter than the access time");

  no_fight_a: assert property ( // R14
    flash_dq_oe_o |-> flash_oe_n_o
  ) else $error("data driven while flash outputs enabled");

  pass_c: cover property (s_reg.st == FSH_EVAL ##1 s_reg.pass);
  timeout_c: cover property (s_reg.st == FSH_EVAL ##1 s_reg.to_fail);
  abort_c: cover property (s_reg.st == FSH_EVAL ##1 s_reg.ab_fail);
  single_c: cover property (s_reg.single && s_reg.st == FSH_EVAL ##1 s_reg.done);

endmodule : fsh_poll_ctrl

// *** dv/fsh_flash_model.sv ***
// Behavioural parallel flash that answers status reads and command writes on its pins.
// Assumes the bench loads each operation through load_i while the host is idle.
`timescale 1ns/10ps

module fsh_flash_model #(
  parameter logic [7:0] ARRAY_BYTE = 8'h40
) (
  input  wire logic [23:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        load_i,
  input  wire logic [7:0]  cnt_i,
  input  wire logic        timeout_i,
  input  wire logic        abort_i,
  input  wire logic        erase_i,
  input  wire logic        susp_i,
  output logic      [7:0]  dq_o,
  output logic             ready_busy_line_o,
  output int               wr_cnt_o,
  output logic      [23:0] wr_addr_o,
  output logic      [7:0]  wr_data_o,
  output logic      [23:0] rd_addr_o
);
  logic [7:0] busy_cnt = 8'h00;
  logic       tog1     = 1'b0;
  logic       tog2     = 1'b0;
  logic       to_flag  = 1'b0;
  logic       ab_flag  = 1'b0;
  logic [7:0] st;
  wire        rd_end   = ce_n_i | oe_n_i;

  initial wr_cnt_o = 0;

  // Operation length counted in status reads, so short protected runs fit too
  always @(posedge load_i) begin
    busy_cnt = cnt_i;
    tog1 = 1'b0;
    to_flag = timeout_i;
    ab_flag = abort_i;
  end

  // Either strobe rising ends a read cycle
  always @(posedge rd_end) begin
    rd_addr_o = addr_i;
    if (busy_cnt != 8'h00) begin
      tog1 = ~tog1;
      busy_cnt = busy_cnt - 8'h01;
    end
    if (erase_i) tog2 = ~tog2;
  end

  always @(posedge we_n_i) begin
    wr_cnt_o = wr_cnt_o + 1;
    wr_addr_o = addr_i;
    wr_data_o = dq_i;
    if (dq_i == 8'hF0) begin
      busy_cnt = 8'h00;
      to_flag = 1'b0;
      ab_flag = 1'b0;
    end
  end

  always_comb begin
    if (busy_cnt != 8'h00) begin
      st = {~(ARRAY_BYTE[7] | erase_i), tog1, to_flag, 1'b0, erase_i, tog2, ab_flag, 1'b0};
    end else if (susp_i) begin
      st = {1'b1, tog1, 1'b0, 1'b0, 1'b0, tog2, 2'b00};
    end else begin
      st = ARRAY_BYTE;
    end
  end

  // Lines float outside a read, so never repeat the last byte there
  assign dq_o = (!ce_n_i && !oe_n_i) ? st : ~st;
  assign ready_busy_line_o = (busy_cnt == 8'h00);
endmodule : fsh_flash_model

// *** dv/fsh_poll_ctrl_tb.sv ***
// Self-checking bench of the toggle-polling flash host.
// Assumes the behavioural flash model and an APB master built from tasks here.
`timescale 1ns/10ps
`include "fsh_params.svh"

module fsh_poll_ctrl_tb
  import fsh_pkg::*;
;
  typedef struct {
    logic pace; logic [7:0] cnt; logic to; logic ab; logic [3:0] flags; int nwr;
  } fsh_row_t;

  logic        clk_i     = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, ce_n, oe_n, we_n, host_oe, rb_line;
  logic [23:0] fl_addr, wr_addr, rd_addr;
  logic [7:0]  host_dq, fl_dq, wr_data, ld_cnt = 8'h00;
  logic        ld_go = 1'b0, ld_to = 1'b0, ld_ab = 1'b0, ld_er = 1'b0, ld_sp = 1'b0;
  int          wr_cnt, n_fail = 0, cmp_count = 0;
  wire  [7:0]  dq_bus = host_oe ? host_dq : fl_dq;
  // Rows: pace, reads busy, timeout, abort, {abort, timeout, pass, done}, writes
  fsh_row_t    rows [6] = '{'{1'b0, 8'h03, 1'b0, 1'b0, 4'b0011, 0},
                            '{1'b1, 8'h04, 1'b0, 1'b0, 4'b0011, 0},
                            '{1'b0, 8'h02, 1'b1, 1'b0, 4'b0011, 0},
                            '{1'b1, 8'hC8, 1'b1, 1'b0, 4'b0101, 1},
                            '{1'b0, 8'hC8, 1'b0, 1'b1, 4'b1001, 3},
                            '{1'b0, 8'h00, 1'b0, 1'b0, 4'b0011, 0}};

  always #20 clk_i = ~clk_i;

  fsh_poll_ctrl #(.AW(24)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .flash_addr_o(fl_addr),
    .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_i(dq_bus),
    .flash_dq_o(host_dq), .flash_dq_oe_o(host_oe), .ready_busy_line_i(rb_line));

  fsh_flash_model u_flash (.addr_i(fl_addr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .dq_i(dq_bus), .load_i(ld_go), .cnt_i(ld_cnt), .timeout_i(ld_to), .abort_i(ld_ab),
    .erase_i(ld_er), .susp_i(ld_sp), .dq_o(fl_dq), .ready_busy_line_o(rb_line),
    .wr_cnt_o(wr_cnt), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr));

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  // Polls STATUS until busy drops; a hang ends the run
  task automatic wait_idle(output logic [31:0] st);
    logic e;
    int   k;
    for (k = 0; k < 100; k++) begin
      apb(1'b0, `FSH_REG_STATUS, 32'h0000_0000, st, e);
      if (st[`FSH_ST_BUSY] === 1'b0) break;
    end
    if (k == 100) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_idle

  task automatic load(input logic [7:0] c, input logic t, a, er, sp);
    @(posedge clk_i);
    ld_cnt <= c;
    ld_to <= t;
    ld_ab <= a;
    ld_er <= er;
    ld_sp <= sp;
    ld_go <= 1'b1;
    @(posedge clk_i);
    ld_go <= 1'b0;
  endtask : load

  task automatic op(input logic [31:0] ctrl, output logic [31:0] st);
    wr(`FSH_REG_CTRL, ctrl);
    wait_idle(st);
  endtask : op

  initial begin
    logic [31:0] st, st2;
    logic        e;
    int          w0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, `FSH_REG_STATUS, 32'h0000_0000, st, e);
    check("status after reset", st, 32'h0000_0040);
    apb(1'b0, 8'h10, 32'h0000_0000, st, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", st, 32'h0000_0000);
    wr(`FSH_REG_ADDR, 32'h00AB_CDEF);
    apb(1'b0, `FSH_REG_ADDR, 32'h0000_0000, st, e);
    check("address readback", st, 32'h00AB_CDEF);
    apb(1'b0, `FSH_REG_CTRL, 32'h0000_0000, st, e);
    check("control reads zero", st, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(`FSH_REG_CFG, {31'h0000_0000, rows[i].pace});
      wr(`FSH_REG_ADDR, 32'h0001_2340 + i);
      load(rows[i].cnt, rows[i].to, rows[i].ab, 1'b0, 1'b0);
      w0 = wr_cnt;
      op(32'h0000_0001, st);
      check("outcome flags", st[4:1], rows[i].flags);
      check("command writes", wr_cnt - w0, rows[i].nwr);
      check("poll address", rd_addr, 32'h0001_2340 + i);
      if (rows[i].nwr > 0) check("last command", {wr_addr, wr_data}, 32'h0005_55F0);
      apb(1'b0, `FSH_REG_STATUS, 32'h0000_0000, st, e);
      check("ready after", st[`FSH_ST_RDY], 1'b1);
    end
    // Stop mid-poll, then a fresh start must poll from scratch
    load(8'hC8, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`FSH_REG_CTRL, 32'h0000_0001);
    op(32'h0000_0010, st);
    check("stop flags", st[4:1], 4'b0001);
    load(8'h01, 1'b0, 1'b0, 1'b0, 1'b0);
    op(32'h0000_0001, st);
    check("restart flags", st[4:1], 4'b0011);
    load(8'hC8, 1'b0, 1'b0, 1'b1, 1'b0);
    op(32'h0000_0002, st);
    op(32'h0000_0002, st2);
    check("erase status", {st[15], st[13], st[11], st[6]}, 4'b0010);
    check("erase toggles", {st[14] ^ st2[14], st[10] ^ st2[10]}, 2'b11);
    load(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
    op(32'h0000_0002, st);
    op(32'h0000_0002, st2);
    check("suspend status", {st[15], st[14] ^ st2[14], st[10] ^ st2[10], st[6]},
          4'b1011);
    op(32'h0000_0001, st);
    check("suspend poll", st[5:1], 5'b10011);
    w0 = wr_cnt;
    op(32'h0000_0004, st);
    check("reset writes", wr_cnt - w0, 1);
    check("reset command", {wr_addr, wr_data}, 32'h0005_55F0);
    op(32'h0000_0008, st);
    check("abort reset writes", wr_cnt - w0, 4);
    check("abort reset done", st[1:0], 2'b10);
    load(8'hC8, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(`FSH_REG_CTRL, 32'h0000_0001);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check("pins in reset", {ce_n, oe_n, we_n, host_oe}, 4'b1110);
    arst_n_i <= 1'b1;
    apb(1'b0, `FSH_REG_STATUS, 32'h0000_0000, st, e);
    check("flags after reset", st[4:0], 5'b00000);
    print_verdict();
  end
endmodule : fsh_poll_ctrl_tb
